// [core/adct_params.svh]
// Constants for the conversion-result I2C target
`ifndef ADCT_PARAMS_SVH
`define ADCT_PARAMS_SVH

`define ADCT_TGT_ADDR    7'h5e
`define ADCT_BYTE_BITS   4'h8
`define ADCT_RES_W       12
`define ADCT_NUM_IN      6
`define ADCT_RES_RST     12'h000
`define ADCT_UNMAPPED    8'h00
`define ADCT_HI_PAD      4'h0
`define ADCT_PTR_RST     8'h00

`define ADCT_REG_IN0_LO  8'h30
`define ADCT_REG_IN0_HI  8'h31
`define ADCT_REG_IN1_LO  8'h26
`define ADCT_REG_IN1_HI  8'h27
`define ADCT_REG_IN2_LO  8'h28
`define ADCT_REG_IN2_HI  8'h29
`define ADCT_REG_IN3_LO  8'h36
`define ADCT_REG_IN3_HI  8'h37
`define ADCT_REG_IN4_LO  8'h34
`define ADCT_REG_IN4_HI  8'h35
`define ADCT_REG_IN5_LO  8'h2e
`define ADCT_REG_IN5_HI  8'h2f

`endif

// [core/adct_pkg.sv]
// Types for the conversion-result I2C target
`default_nettype none
package adct_pkg;
  typedef logic [11:0] adct_sample_t;
  typedef logic [5:0][11:0] adct_bank_t;
  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ADDR      = 4'h1,
    ST_ACK_ADDR  = 4'h2,
    ST_REG       = 4'h3,
    ST_ACK_REG   = 4'h4,
    ST_WDATA     = 4'h5,
    ST_ACK_WDATA = 4'h6,
    ST_RDATA     = 4'h7,
    ST_MACK      = 4'h8
  } adct_state_t;
endpackage
`default_nettype wire

// [core/adct_sync.sv]
// Two-flop synchroniser for asynchronous pin inputs
`default_nettype none
module adct_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // Idle bus level is high, so reset to released
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          meta[i]     <= 1'b1;
          sync_out[i] <= 1'b1;
        end else begin
          meta[i]     <= async_in[i];
          sync_out[i] <= meta[i];
        end
      end
    end
  endgenerate
endmodule // adct_sync
`default_nettype wire

// [core/adct_target.sv]
// I2C target serving six read-only 12-bit conversion results
// How it works
// - The target answers only at 7-bit address 0x5E and the controller uses it.
// - Both 100 kHz and 400 kHz serial clocks are served correctly.
// - Each 12-bit result is exposed as two consecutive 8-bit registers.
// - All result registers are read-only; writes never alter a result.
// - Inputs 0, 1 and 2 sit at pairs starting 0x30, 0x26 and 0x28.
// - Inputs 3, 4 and 5 sit at pairs starting 0x36, 0x34 and 0x2E.
// - For input 0, 0x30 holds the low byte, 0x31 the upper bits.
// - Inputs 0 to 5 come from converter channel 5, the dedicated input, and channels 1, 8, 7 and 4.
// - Only six converter channels are mapped; current-sense ones are not.
`include "adct_params.svh"
`default_nettype none
module adct_target (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output var  logic                  sda_out,
  output var  logic                  sda_oe_n,
  input  wire logic                  conv_update,
  input  wire adct_pkg::adct_sample_t converter_channel_five,
  input  wire adct_pkg::adct_sample_t converter_dedicated_input,
  input  wire adct_pkg::adct_sample_t converter_channel_one,
  input  wire adct_pkg::adct_sample_t converter_channel_eight,
  input  wire adct_pkg::adct_sample_t converter_channel_seven,
  input  wire adct_pkg::adct_sample_t converter_channel_four
);
  import adct_pkg::*;

  logic [1:0]  pins_s;
  logic        scl_s;
  logic        sda_s;
  logic        scl_d;
  logic        sda_d;
  logic        next_scl_d;
  logic        next_sda_d;
  adct_state_t state;
  adct_state_t next_state;
  logic [3:0]  cnt;
  logic [3:0]  next_cnt;
  logic [7:0]  shreg;
  logic [7:0]  next_shreg;
  logic [7:0]  tx;
  logic [7:0]  next_tx;
  logic [7:0]  ptr;
  logic [7:0]  next_ptr;
  logic        next_oe_n;
  adct_bank_t  result;
  adct_bank_t  next_result;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_cond;
  logic        stop_cond;

  // Pins are asynchronous to mclk
  adct_sync #(.WIDTH(2)) u_sync (
    .mclk     (mclk),
    .rst      (rst),
    .async_in ({scl_in, sda_in}),
    .sync_out (pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Sampling at 250 MHz leaves a wide margin even at the fast bus rate
  assign scl_rise   = scl_s & ~scl_d;
  assign scl_fall   = ~scl_s & scl_d;
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;

  // Byte lookup; unmapped addresses read as zero
  function automatic logic [7:0] read_byte(input logic [7:0] a,
                                           input adct_bank_t r);
    case (a)
      `ADCT_REG_IN0_LO: read_byte = r[0][7:0];
      `ADCT_REG_IN0_HI: read_byte = {`ADCT_HI_PAD, r[0][11:8]};
      `ADCT_REG_IN1_LO: read_byte = r[1][7:0];
      `ADCT_REG_IN1_HI: read_byte = {`ADCT_HI_PAD, r[1][11:8]};
      `ADCT_REG_IN2_LO: read_byte = r[2][7:0];
      `ADCT_REG_IN2_HI: read_byte = {`ADCT_HI_PAD, r[2][11:8]};
      `ADCT_REG_IN3_LO: read_byte = r[3][7:0];
      `ADCT_REG_IN3_HI: read_byte = {`ADCT_HI_PAD, r[3][11:8]};
      `ADCT_REG_IN4_LO: read_byte = r[4][7:0];
      `ADCT_REG_IN4_HI: read_byte = {`ADCT_HI_PAD, r[4][11:8]};
      `ADCT_REG_IN5_LO: read_byte = r[5][7:0];
      `ADCT_REG_IN5_HI: read_byte = {`ADCT_HI_PAD, r[5][11:8]};
      default:          read_byte = `ADCT_UNMAPPED;
    endcase
  endfunction

  always_comb begin
    logic [7:0] rd;
    rd          = read_byte(ptr, result);
    next_scl_d  = scl_s;
    next_sda_d  = sda_s;
    next_state  = state;
    next_cnt    = cnt;
    next_shreg  = shreg;
    next_tx     = tx;
    next_ptr    = ptr;
    next_oe_n   = sda_oe_n;
    next_result = result;
    // Only the converter strobe loads results; bus writes cannot reach them
    if (conv_update) begin
      next_result = {converter_channel_four, converter_channel_seven,
                     converter_channel_eight, converter_channel_one,
                     converter_dedicated_input,
                     converter_channel_five};
    end
    if (start_cond) begin
      next_state = ST_ADDR;
      next_cnt   = 4'h0;
      next_oe_n  = 1'b1;
    end else if (stop_cond) begin
      next_state = ST_IDLE;
      next_oe_n  = 1'b1;
    end else if (scl_rise) begin
      case (state)
        ST_ADDR, ST_REG, ST_WDATA: begin
          next_shreg = {shreg[6:0], sda_s};
          next_cnt   = cnt + 4'h1;
        end
        ST_RDATA: next_cnt = cnt + 4'h1;
        // Controller acknowledge: low means keep sending
        ST_MACK: next_shreg = {shreg[6:0], sda_s};
        default: ;
      endcase
    end else if (scl_fall) begin
      case (state)
        ST_ADDR: begin
          if (cnt == `ADCT_BYTE_BITS) begin
            if (shreg[7:1] == `ADCT_TGT_ADDR) begin
              next_state = ST_ACK_ADDR;
              next_oe_n  = 1'b0;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        ST_ACK_ADDR: begin
          next_cnt = 4'h0;
          if (shreg[0]) begin
            next_state = ST_RDATA;
            next_tx    = rd;
            next_oe_n  = rd[7];
            next_ptr   = ptr + 8'h01;
          end else begin
            next_state = ST_REG;
            next_oe_n  = 1'b1;
          end
        end
        ST_REG: begin
          if (cnt == `ADCT_BYTE_BITS) begin
            next_state = ST_ACK_REG;
            next_ptr   = shreg;
            next_oe_n  = 1'b0;
          end
        end
        ST_ACK_REG, ST_ACK_WDATA: begin
          next_state = ST_WDATA;
          next_cnt   = 4'h0;
          next_oe_n  = 1'b1;
        end
        ST_WDATA: begin
          // Data is acknowledged and dropped, the pointer still advances
          if (cnt == `ADCT_BYTE_BITS) begin
            next_state = ST_ACK_WDATA;
            next_ptr   = ptr + 8'h01;
            next_oe_n  = 1'b0;
          end
        end
        ST_RDATA: begin
          if (cnt == `ADCT_BYTE_BITS) begin
            next_state = ST_MACK;
            next_oe_n  = 1'b1;
          end else begin
            next_tx   = {tx[6:0], 1'b0};
            next_oe_n = tx[6];
          end
        end
        ST_MACK: begin
          next_cnt = 4'h0;
          if (!shreg[0]) begin
            next_state = ST_RDATA;
            next_tx    = rd;
            next_oe_n  = rd[7];
            next_ptr   = ptr + 8'h01;
          end else begin
            next_state = ST_IDLE;
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
      state    <= ST_IDLE;
      cnt      <= 4'h0;
      shreg    <= 8'h00;
      tx       <= 8'h00;
      ptr      <= `ADCT_PTR_RST;
      sda_oe_n <= 1'b1;
      sda_out  <= 1'b0;
      result   <= {`ADCT_NUM_IN{`ADCT_RES_RST}};
    end else begin
      scl_d    <= next_scl_d;
      sda_d    <= next_sda_d;
      state    <= next_state;
      cnt      <= next_cnt;
      shreg    <= next_shreg;
      tx       <= next_tx;
      ptr      <= next_ptr;
      sda_oe_n <= next_oe_n;
      sda_out  <= 1'b0;
      result   <= next_result;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  property p_ack_own_addr;
    (state == ST_ACK_ADDR) |-> (shreg[7:1] == `ADCT_TGT_ADDR);
  endproperty
  a_ack_own_addr: assert property (p_ack_own_addr)
    else $error("address acknowledged for a foreign address");

  property p_foreign_addr_released;
    (state == ST_ADDR && scl_fall && !start_cond && !stop_cond &&
     cnt == `ADCT_BYTE_BITS && shreg[7:1] != `ADCT_TGT_ADDR)
      |=> (state == ST_IDLE) && sda_oe_n;
  endproperty
  a_foreign_addr_released: assert property (p_foreign_addr_released)
    else $error("foreign address not released");

  property p_drive_after_fall;
    $fell(sda_oe_n) |-> $past(scl_fall);
  endproperty
  a_drive_after_fall: assert property (p_drive_after_fall)
    else $error("data line driven outside a clock low phase");

  property p_results_read_only;
    !conv_update |=> $stable(result);
  endproperty
  a_results_read_only: assert property (p_results_read_only)
    else $error("result changed without a converter update");

  property p_channel_map;
    conv_update |=> result[0] == $past(converter_channel_five) &&
                    result[1] == $past(converter_dedicated_input) &&
                    result[3] == $past(converter_channel_eight) &&
                    result[5] == $past(converter_channel_four);
  endproperty
  a_channel_map: assert property (p_channel_map)
    else $error("converter channel mapped to wrong input");

  property p_map_low;
    read_byte(`ADCT_REG_IN1_LO, result) == result[1][7:0] &&
    read_byte(`ADCT_REG_IN2_LO, result) == result[2][7:0];
  endproperty
  a_map_low: assert property (p_map_low)
    else $error("low byte of input 1 or 2 misplaced");

  property p_map_upper;
    read_byte(`ADCT_REG_IN3_LO, result) == result[3][7:0] &&
    read_byte(`ADCT_REG_IN4_HI, result) == {4'h0, result[4][11:8]} &&
    read_byte(`ADCT_REG_IN5_LO, result) == result[5][7:0];
  endproperty
  a_map_upper: assert property (p_map_upper)
    else $error("input 3, 4 or 5 misplaced");

  property p_in0_order;
    read_byte(`ADCT_REG_IN0_HI, result) == {4'h0, result[0][11:8]} &&
    read_byte(`ADCT_REG_IN0_LO, result) == result[0][7:0];
  endproperty
  a_in0_order: assert property (p_in0_order)
    else $error("input 0 byte order wrong");

  property p_hi_pad_zero;
    (read_byte({ptr[7:1], 1'b1}, result) & 8'hf0) == 8'h00;
  endproperty
  a_hi_pad_zero: assert property (p_hi_pad_zero)
    else $error("upper nibble of a high register not zero");

  property p_unmapped_zero;
    read_byte(8'h00, result) == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped register reads nonzero");

  c_addr_ack: cover property (state == ST_ACK_ADDR);
  c_write_drop: cover property (state == ST_ACK_WDATA);
  c_burst_read: cover property (state == ST_MACK && scl_fall && !shreg[0]);
endmodule // adct_target
`default_nettype wire

// [testbench/adct_i2c_ctrl.sv]
// Behavioural I2C controller that fetches conversion results
`default_nettype none
module adct_i2c_ctrl (
  input  wire logic mclk,
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  // Half SCL period in mclk cycles; 312 and 1250 give 400 and 100 kHz
  int hp = 24;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Also serves as repeated start from mid-frame with SCL low
  task automatic start_cond();
    tick(hp / 2);
    sda_pull = 1'b0;
    tick(hp / 2);
    scl = 1'b1;
    tick(hp);
    sda_pull = 1'b1;
    tick(hp);
    scl = 1'b0;
  endtask
  task automatic stop_cond();
    tick(hp / 2);
    sda_pull = 1'b1;
    tick(hp / 2);
    scl = 1'b1;
    tick(hp);
    sda_pull = 1'b0;
    tick(hp);
  endtask
  // Eight data bits then the acknowledge bit; sending 1 releases SDA
  task automatic xfer(input logic [7:0] d, input logic a_out,
                      output logic [7:0] q, output logic a_in);
    for (int i = 7; i >= -1; i--) begin
      tick(hp / 2);
      sda_pull = (i >= 0) ? !d[i] : !a_out;
      tick(hp / 2);
      scl = 1'b1;
      tick(hp / 2);
      if (i >= 0) q[i] = sda;
      else a_in = sda;
      tick(hp / 2);
      scl = 1'b0;
    end
  endtask
  task automatic probe(input logic [6:0] dev, output logic ack_n);
    logic [7:0] q;
    start_cond();
    xfer({dev, 1'b0}, 1'b1, q, ack_n);
    stop_cond();
  endtask
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                           input logic [7:0] d, output logic ack_n);
    logic [7:0] q;
    logic a0, a1, a2;
    start_cond();
    xfer({dev, 1'b0}, 1'b1, q, a0);
    xfer(ptr, 1'b1, q, a1);
    xfer(d, 1'b1, q, a2);
    stop_cond();
    ack_n = a0 | a1 | a2;
  endtask
  task automatic read_pair(input logic [6:0] dev, input logic [7:0] ptr,
                           output logic [11:0] res, output logic [7:0] hi,
                           output logic ack_n);
    logic [7:0] lo;
    logic a0, a1, a2, x;
    start_cond();
    xfer({dev, 1'b0}, 1'b1, lo, a0);
    xfer(ptr, 1'b1, lo, a1);
    start_cond();
    xfer({dev, 1'b1}, 1'b1, lo, a2);
    xfer(8'hff, 1'b0, lo, x);
    xfer(8'hff, 1'b1, hi, x);
    stop_cond();
    res = {hi[3:0], lo};
    ack_n = a0 | a1 | a2;
  endtask
endmodule // adct_i2c_ctrl
`default_nettype wire

// [testbench/adct_target_tb_top.sv]
// Testbench for the conversion-result I2C target
`default_nettype none
module adct_target_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import adct_pkg::*;
  logic         mclk, rst, conv_update, scl, sda_pull, sda_out, sda_oe_n;
  wire          sda;
  adct_sample_t vals [6];
  logic [7:0]   lo_addr [6] = '{8'h30, 8'h26, 8'h28, 8'h36, 8'h34, 8'h2e};
  logic [11:0]  res;
  logic [7:0]   hi;
  logic         ack_n;
  int           err_total, tests_run;
  // Open-drain line with pull-up
  assign sda = !sda_pull && (sda_oe_n || sda_out);
  adct_i2c_ctrl ctrl (.mclk(mclk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
  adct_target uut (
    .mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .conv_update(conv_update),
    .converter_channel_five(vals[0]), .converter_dedicated_input(vals[1]),
    .converter_channel_one(vals[2]), .converter_channel_eight(vals[3]),
    .converter_channel_seven(vals[4]), .converter_channel_four(vals[5]));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [11:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic t_reset();
    chk("idle release", {11'h000, sda_oe_n}, 12'h001);
    chk("drive level", {11'h000, sda_out}, 12'h000);
    ctrl.read_pair(7'h5e, 8'h30, res, hi, ack_n);
    chk("address ack", {11'h000, ack_n}, 12'h000);
    chk("reset result", res, 12'h000);
  endtask
  task automatic t_map();
    vals = '{12'h3b9, 12'ha5c, 12'h1f0, 12'hf0f, 12'h0ed, 12'h842};
    @(posedge mclk);
    #1 conv_update = 1'b1;
    @(posedge mclk);
    #1 conv_update = 1'b0;
    for (int i = 0; i < 6; i++) begin
      ctrl.read_pair(7'h5e, lo_addr[i], res, hi, ack_n);
      chk("mapped result", res, vals[i]);
      chk("high pad", {8'h00, hi[7:4]}, 12'h000);
    end
    // Gap between pairs belongs to no input
    ctrl.read_pair(7'h5e, 8'h2c, res, hi, ack_n);
    chk("unmapped low", res, 12'h000);
    chk("unmapped high", {4'h0, hi}, 12'h000);
  endtask
  task automatic t_write();
    ctrl.write_reg(7'h5e, 8'h30, 8'ha5, ack_n);
    chk("write ack", {11'h000, ack_n}, 12'h000);
    ctrl.write_reg(7'h5e, 8'h31, 8'h0c, ack_n);
    ctrl.read_pair(7'h5e, 8'h30, res, hi, ack_n);
    chk("after write", res, vals[0]);
  endtask
  task automatic t_bad_addr();
    ctrl.probe(7'h5f, ack_n);
    chk("foreign nack", {11'h000, ack_n}, 12'h001);
    ctrl.probe(7'h2f, ack_n);
    chk("foreign nack", {11'h000, ack_n}, 12'h001);
    ctrl.read_pair(7'h5e, 8'h26, res, hi, ack_n);
    chk("recovered", res, vals[1]);
  endtask
  task automatic t_rates();
    ctrl.hp = 312;
    ctrl.probe(7'h5e, ack_n);
    chk("400k ack", {11'h000, ack_n}, 12'h000);
    ctrl.hp = 1250;
    ctrl.probe(7'h5e, ack_n);
    chk("100k ack", {11'h000, ack_n}, 12'h000);
    ctrl.hp = 24;
  endtask
  initial begin
    rst = 1'b1;
    conv_update = 1'b0;
    vals = '{default: 12'h000};
    err_total = 0;
    tests_run = 0;
    repeat (3) @(posedge mclk);
    #1 rst = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    t_reset();
    t_map();
    t_write();
    t_bad_addr();
    t_rates();
    conclude();
  end
  // Expected run is about 65300 cycles
  initial begin
    repeat (95000) @(posedge mclk);
    err_total++;
    conclude();
  end
endmodule // adct_target_tb_top
`default_nettype wire
